// [sim/cspc_card_model.sv]
// behavioural model of the inserted card and the host clock-run master
`timescale 1ns/10ps

module cspc_card_model (
  // card side pins
  output logic card_clk_out,
  output logic card_bus_active_out,
  output cspc_pkg::cspc_caps_t card_caps_out,
  // host clock-run request
  output logic host_stop_req_out
);
  import cspc_pkg::*;

  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    card_clk_out = 1'b0;
    card_bus_active_out = 1'b0;
    card_caps_out = 6'h00;
    host_stop_req_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // card clock bursts
  // ----------------------------------------------------------------
  // the clock stands still between bursts; the odd start offset keeps its phase apart from clk_sys_in
  task automatic run_edges(input int n);
    #1.3;
    repeat (n) begin
      card_clk_out = 1'b1;
      #40;
      card_clk_out = 1'b0;
      #40;
    end
  endtask

  task automatic set_pins(input logic active, input logic [5:0] caps, input logic host_stop);
    card_bus_active_out <= active;
    card_caps_out <= caps;
    host_stop_req_out <= host_stop;
  endtask
endmodule

// [sim/testbench.sv]
// self-checking bench for the socket supply and idle clock controller
`timescale 1ns/10ps

module testbench;
  import cspc_pkg::*;

  logic clk_sys_in;
  logic sys_rst_in;
  logic clk_en_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [31:0] reg_rdata_out;
  logic card_clk_in;
  logic card_bus_active_in;
  cspc_caps_t card_caps_in;
  logic host_stop_req_in;
  logic [2:0] card_supply_out;
  logic [2:0] prog_supply_out;
  logic card_clk_stop_req_out;
  logic card_clk_slow_req_out;
  logic [4:0] card_clk_divisor_out;
  logic irq_out;
  int bad_count;
  int n_compared;
  logic [2:0] exp_sup;

  cspc_top u_cspc_top (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .card_clk_in(card_clk_in),
    .card_bus_active_in(card_bus_active_in), .card_caps_in(card_caps_in),
    .host_stop_req_in(host_stop_req_in), .card_supply_out(card_supply_out),
    .prog_supply_out(prog_supply_out), .card_clk_stop_req_out(card_clk_stop_req_out),
    .card_clk_slow_req_out(card_clk_slow_req_out), .card_clk_divisor_out(card_clk_divisor_out),
    .irq_out(irq_out)
  );

  cspc_card_model u_cspc_card_model (
    .card_clk_out(card_clk_in), .card_bus_active_out(card_bus_active_in),
    .card_caps_out(card_caps_in), .host_stop_req_out(host_stop_req_in)
  );

  // ----------------------------------------------------------------
  // clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #200000;
    bad_count = bad_count + 1;
    finish_test();
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count = bad_count + 1;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys_in);
    reg_addr_in <= addr;
    reg_wdata_in <= data;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic reg_read(input logic [7:0] addr, input logic [31:0] exp, input string what);
    @(posedge clk_sys_in);
    reg_addr_in <= addr;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    check(what, exp, reg_rdata_out);
  endtask

  task automatic pins(input logic active, input logic [5:0] caps, input logic host_stop);
    @(posedge clk_sys_in);
    u_cspc_card_model.set_pins(active, caps, host_stop);
    wait_cyc(6);
  endtask

  // a short burst of bus activity returns the clock-run logic to normal running
  task automatic activity_pulse(input logic [5:0] caps, input logic host_stop);
    pins(1'b1, caps, host_stop);
    pins(1'b0, caps, host_stop);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    n_compared = 0;
    clk_en_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    sys_rst_in = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    check("divisor at reset", 32'h1, {27'h0, card_clk_divisor_out});
    reg_read(CSPC_OFS_CTRL, 32'h0, "ctrl reset");
    reg_read(CSPC_OFS_PM, 32'h0, "pm reset");
    reg_read(8'h44, 32'h0, "unmapped read");

    // refused supply requests raise the masked interrupt
    pins(1'b0, 6'h28, 1'b0);
    reg_write(CSPC_OFS_IRQ_MASK, 32'h4);
    reg_write(CSPC_OFS_CTRL, 32'h30);
    wait_cyc(3);
    check("card supply kept", 32'h0, {29'h0, card_supply_out});
    check("irq on refusal", 32'h1, {31'h0, irq_out});
    reg_read(CSPC_OFS_IRQ_STAT, 32'h4, "irq status refused");
    reg_write(CSPC_OFS_IRQ_STAT, 32'h4);
    wait_cyc(3);
    check("irq after clear", 32'h0, {31'h0, irq_out});
    reg_write(CSPC_OFS_CTRL, 32'h21);
    wait_cyc(3);
    check("card 5v accepted", 32'h2, {29'h0, card_supply_out});
    check("prog 12v refused", 32'h0, {29'h0, prog_supply_out});
    reg_write(CSPC_OFS_IRQ_MASK, 32'h0);
    wait_cyc(3);
    check("irq masked", 32'h0, {31'h0, irq_out});
    reg_write(CSPC_OFS_IRQ_STAT, 32'h7);

    // every code of both supply fields with a card that takes all voltages
    pins(1'b0, 6'h3f, 1'b0);
    reg_write(CSPC_OFS_CTRL, 32'h0);
    exp_sup = 3'h0;
    for (int i = 0; i < 8; i++) begin
      reg_write(CSPC_OFS_CTRL, {25'h0, i[2:0], 4'h0});
      if (i != 1 && i < 6) exp_sup = i[2:0];
      wait_cyc(2);
      check("card supply code", {29'h0, exp_sup}, {29'h0, card_supply_out});
    end
    reg_write(CSPC_OFS_CTRL, 32'h0);
    exp_sup = 3'h0;
    for (int i = 0; i < 8; i++) begin
      reg_write(CSPC_OFS_CTRL, {29'h0, i[2:0]});
      if (i < 6) exp_sup = i[2:0];
      wait_cyc(2);
      check("prog supply code", {29'h0, exp_sup}, {29'h0, prog_supply_out});
    end
    reg_write(CSPC_OFS_CTRL, 32'hffff_ffbb);
    reg_read(CSPC_OFS_CTRL, 32'hb3, "ctrl reserved bits");
    reg_write(CSPC_OFS_PM, 32'hfffe_fffe);
    reg_read(CSPC_OFS_PM, 32'h0, "pm reserved bits");
    pins(1'b0, 6'h00, 1'b0);
    check("supplies off when card gone", 32'h0, {26'h0, card_supply_out, prog_supply_out});
    reg_write(CSPC_OFS_CTRL, 32'h0);

    // stop policy clear: idle alone is not enough
    reg_write(CSPC_OFS_PM, 32'h0001_0000);
    u_cspc_card_model.run_edges(9);
    wait_cyc(2);
    check("no stop without host", 32'h0, {31'h0, card_clk_stop_req_out});
    pins(1'b0, 6'h00, 1'b1);
    check("stop with host request", 32'h1, {31'h0, card_clk_stop_req_out});
    reg_read(CSPC_OFS_PM, 32'h0101_0000, "clock changed flag");
    pins(1'b1, 6'h00, 1'b1);
    check("stop drops on activity", 32'h0, {31'h0, card_clk_stop_req_out});
    pins(1'b0, 6'h00, 1'b0);
    reg_read(CSPC_OFS_PM, 32'h0201_0000, "accessed flag set");
    reg_read(CSPC_OFS_PM, 32'h0001_0000, "accessed flag cleared");

    // stop policy set: eight consecutive idle edges, host request ignored
    reg_write(CSPC_OFS_CTRL, 32'h80);
    u_cspc_card_model.run_edges(7);
    activity_pulse(6'h00, 1'b0);
    u_cspc_card_model.run_edges(7);
    wait_cyc(2);
    check("seven idle edges", 32'h0, {31'h0, card_clk_stop_req_out});
    u_cspc_card_model.run_edges(1);
    wait_cyc(2);
    check("eighth idle edge", 32'h1, {31'h0, card_clk_stop_req_out});

    // slow mode divides by sixteen
    activity_pulse(6'h00, 1'b0);
    reg_write(CSPC_OFS_PM, 32'h0001_0001);
    u_cspc_card_model.run_edges(8);
    wait_cyc(2);
    check("slow request", 32'h1, {31'h0, card_clk_slow_req_out});
    check("slow divisor", 32'h10, {27'h0, card_clk_divisor_out});
    check("no stop in slow mode", 32'h0, {31'h0, card_clk_stop_req_out});
    reg_read(CSPC_OFS_PM, 32'h0301_0001, "changed flag slow");

    // clock control disabled never requests
    activity_pulse(6'h00, 1'b0);
    reg_write(CSPC_OFS_PM, 32'h0000_0001);
    u_cspc_card_model.run_edges(9);
    wait_cyc(2);
    check("disabled requests", 32'h2, {26'h0, card_clk_divisor_out, card_clk_stop_req_out});
    check("disabled slow", 32'h0, {31'h0, card_clk_slow_req_out});

    // a low clock enable freezes all state, a register write included
    pins(1'b0, 6'h3f, 1'b0);
    @(posedge clk_sys_in);
    clk_en_in <= 1'b0;
    reg_write(CSPC_OFS_CTRL, 32'h20);
    wait_cyc(2);
    check("write while frozen", 32'h0, {29'h0, card_supply_out});
    @(posedge clk_sys_in);
    clk_en_in <= 1'b1;
    reg_write(CSPC_OFS_CTRL, 32'h20);
    wait_cyc(2);
    check("write after thaw", 32'h2, {29'h0, card_supply_out});
    finish_test();
  end
endmodule

// [verilog/cspc_pkg.sv]
// shared constants, types and register map of the card socket power and clock controller
//
// How it works
// R1 - policy clear: stop request needs 8 idle card clocks plus host stop request.
// R2 - policy set: stop request after 8 idle card clocks, host request ignored.
// R3 - card supply field: 000 off, 010 5.0V, 011 3.3V, 100/101 extra, others reserved.
// R4 - program supply field: 000 off, 001 12V, 010 5V, 011 3.3V, 100/101 extra.
// R5 - supply requests the inserted card cannot accept are ignored.
// R6 - reserved bits of both registers read zero; writes to them do nothing.
// R7 - card accessed flag, bit 25, set on access, reset zero, cleared by read.
// R8 - clock changed flag, bit 24, reads 1 while card clock stopped or slowed.
// R9 - clock control enable, bit 16, resets 0; 0 disables idle clock control.
// R10 - select bit 0: 0 stops idle clock, 1 slows it by factor 16.
// R11 - idle clock counter restarts on any card bus activity.
package cspc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CSPC_OFS_CTRL = 8'h10;
  localparam logic [7:0] CSPC_OFS_PM = 8'h20;
  localparam logic [7:0] CSPC_OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] CSPC_OFS_IRQ_MASK = 8'h34;

  localparam int CSPC_BIT_STOP_POLICY = 7;
  localparam int CSPC_POS_CARD_SUPPLY = 4;
  localparam int CSPC_POS_PROG_SUPPLY = 0;
  localparam int CSPC_BIT_ACCESSED = 25;
  localparam int CSPC_BIT_CHANGED = 24;
  localparam int CSPC_BIT_CTL_ENABLE = 16;
  localparam int CSPC_BIT_SELECT = 0;

  // interrupt status bits
  localparam int CSPC_IRQ_ACCESS = 0;
  localparam int CSPC_IRQ_CLOCK = 1;
  localparam int CSPC_IRQ_REFUSED = 2;
  localparam logic [2:0] CSPC_IRQ_RESET = 3'h0;

  // ----------------------------------------------------------------
  // supply codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CSPC_SUP_OFF = 3'h0;
  localparam logic [2:0] CSPC_SUP_12V0 = 3'h1;
  localparam logic [2:0] CSPC_SUP_5V0 = 3'h2;
  localparam logic [2:0] CSPC_SUP_3V3 = 3'h3;
  localparam logic [2:0] CSPC_SUP_XV = 3'h4;
  localparam logic [2:0] CSPC_SUP_YV = 3'h5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [3:0] CSPC_IDLE_CLOCKS = 4'h8;
  localparam logic [4:0] CSPC_DIV_NORMAL = 5'h01;
  localparam logic [4:0] CSPC_DIV_SLOW = 5'h10;

  typedef enum logic [1:0] {
    CSPC_CR_RUN = 2'b00,
    CSPC_CR_STOP = 2'b01,
    CSPC_CR_SLOW = 2'b10
  } cspc_cr_state_t;

  typedef struct packed {
    logic stop_policy;
    logic [2:0] card_supply;
    logic [2:0] prog_supply;
  } cspc_ctrl_t;

  typedef struct packed {
    logic present;
    logic v12;
    logic v5;
    logic v3;
    logic vx;
    logic vy;
  } cspc_caps_t;

  localparam cspc_ctrl_t CSPC_CTRL_RESET = '{1'b0, 3'h0, 3'h0};

endpackage

// [verilog/cspc_top.sv]
// card socket supply request and idle clock control logic
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps

// ------------------------------------------------------------------
// two-stage synchroniser
// ------------------------------------------------------------------
module cspc_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else if (en_in) begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// ------------------------------------------------------------------
// top
// ------------------------------------------------------------------
module cspc_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // card side pins
  input wire logic card_clk_in,
  input wire logic card_bus_active_in,
  input wire cspc_pkg::cspc_caps_t card_caps_in,
  // host clock-run request to stop its clock
  input wire logic host_stop_req_in,
  // socket supply and clock control
  output logic [2:0] card_supply_out,
  output logic [2:0] prog_supply_out,
  output logic card_clk_stop_req_out,
  output logic card_clk_slow_req_out,
  output logic [4:0] card_clk_divisor_out,
  // interrupt
  output logic irq_out
);
  import cspc_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic card_clk_s;
  logic active_s;
  logic host_stop_s;
  cspc_caps_t caps_s;

  cspc_sync #(.W(9)) u_sync (
    .clk_in(clk_sys_in),
    .rst_in(sys_rst_in),
    .en_in(clk_en_in),
    .d_in({card_clk_in, card_bus_active_in, host_stop_req_in, card_caps_in}),
    .q_out({card_clk_s, active_s, host_stop_s, caps_s})
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cspc_ctrl_t ctrl_q, ctrl_d;
  logic ctl_enable_q, ctl_enable_d;
  logic select_q, select_d;
  logic accessed_q, accessed_d;
  logic [2:0] irq_stat_q, irq_stat_d;
  logic [2:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic card_clk_prev_q;
  logic active_prev_q;
  logic [3:0] idle_cnt_q, idle_cnt_d;
  cspc_cr_state_t cr_q, cr_d;
  logic stop_q, stop_d;
  logic slow_q, slow_d;
  logic [4:0] divisor_q, divisor_d;

  logic card_edge;
  logic idle_done;
  logic idle_wanted;
  logic wr_ctrl;
  logic rd_pm;
  logic card_ok;
  logic prog_ok;
  logic access_evt;
  logic clock_evt;
  logic refuse_evt;
  cspc_ctrl_t wctrl;

  // ----------------------------------------------------------------
  // supply acceptance
  // ----------------------------------------------------------------
  function automatic logic card_code_ok(input logic [2:0] c, input cspc_caps_t k);
    case (c)
      CSPC_SUP_OFF: card_code_ok = 1'b1;
      CSPC_SUP_5V0: card_code_ok = k.present & k.v5;
      CSPC_SUP_3V3: card_code_ok = k.present & k.v3;
      CSPC_SUP_XV: card_code_ok = k.present & k.vx;
      CSPC_SUP_YV: card_code_ok = k.present & k.vy;
      default: card_code_ok = 1'b0; // [R3]
    endcase
  endfunction

  function automatic logic prog_code_ok(input logic [2:0] c, input cspc_caps_t k);
    case (c)
      CSPC_SUP_OFF: prog_code_ok = 1'b1;
      CSPC_SUP_12V0: prog_code_ok = k.present & k.v12;
      CSPC_SUP_5V0: prog_code_ok = k.present & k.v5;
      CSPC_SUP_3V3: prog_code_ok = k.present & k.v3;
      CSPC_SUP_XV: prog_code_ok = k.present & k.vx;
      CSPC_SUP_YV: prog_code_ok = k.present & k.vy;
      default: prog_code_ok = 1'b0; // [R4]
    endcase
  endfunction

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl = reg_wr_in && (reg_addr_in == CSPC_OFS_CTRL);
    rd_pm = reg_rd_in && (reg_addr_in == CSPC_OFS_PM);
    wctrl.stop_policy = reg_wdata_in[CSPC_BIT_STOP_POLICY];
    wctrl.card_supply = reg_wdata_in[CSPC_POS_CARD_SUPPLY +: 3];
    wctrl.prog_supply = reg_wdata_in[CSPC_POS_PROG_SUPPLY +: 3];
    card_ok = card_code_ok(wctrl.card_supply, caps_s);
    prog_ok = prog_code_ok(wctrl.prog_supply, caps_s);
    refuse_evt = wr_ctrl && !(card_ok && prog_ok);
    access_evt = active_s && !active_prev_q;
    clock_evt = (stop_d && !stop_q) || (slow_d && !slow_q);

    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.stop_policy = wctrl.stop_policy;
      // each supply field is taken only if the card can accept it
      if (card_ok) begin
        ctrl_d.card_supply = wctrl.card_supply; // [R5]
      end
      if (prog_ok) begin
        ctrl_d.prog_supply = wctrl.prog_supply; // [R5]
      end
    end
    // a removed card loses both supplies at once
    if (!caps_s.present) begin
      ctrl_d.card_supply = CSPC_SUP_OFF; // [R5]
      ctrl_d.prog_supply = CSPC_SUP_OFF; // [R5]
    end

    ctl_enable_d = ctl_enable_q;
    select_d = select_q;
    if (reg_wr_in && (reg_addr_in == CSPC_OFS_PM)) begin
      ctl_enable_d = reg_wdata_in[CSPC_BIT_CTL_ENABLE]; // [R9]
      select_d = reg_wdata_in[CSPC_BIT_SELECT]; // [R10]
    end

    // set wins over the clear by read
    accessed_d = access_evt ? 1'b1 : (rd_pm ? 1'b0 : accessed_q); // [R7]

    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (reg_wr_in && (reg_addr_in == CSPC_OFS_IRQ_MASK)) begin
      irq_mask_d = reg_wdata_in[2:0];
    end
    if (reg_wr_in && (reg_addr_in == CSPC_OFS_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~reg_wdata_in[2:0];
    end
    irq_stat_d = irq_stat_d | {refuse_evt, clock_evt, access_evt};
    irq_d = |(irq_stat_d & irq_mask_d);

    rdata_d = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        CSPC_OFS_CTRL: begin
          rdata_d[CSPC_BIT_STOP_POLICY] = ctrl_q.stop_policy; // [R6]
          rdata_d[CSPC_POS_CARD_SUPPLY +: 3] = ctrl_q.card_supply;
          rdata_d[CSPC_POS_PROG_SUPPLY +: 3] = ctrl_q.prog_supply;
        end
        CSPC_OFS_PM: begin
          rdata_d[CSPC_BIT_ACCESSED] = accessed_q; // [R7]
          rdata_d[CSPC_BIT_CHANGED] = stop_q | slow_q; // [R8]
          rdata_d[CSPC_BIT_CTL_ENABLE] = ctl_enable_q; // [R6]
          rdata_d[CSPC_BIT_SELECT] = select_q;
        end
        CSPC_OFS_IRQ_STAT: begin
          rdata_d[2:0] = irq_stat_q;
        end
        CSPC_OFS_IRQ_MASK: begin
          rdata_d[2:0] = irq_mask_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // idle counting and clock-run state machine
  // ----------------------------------------------------------------
  always_comb begin
    card_edge = card_clk_s && !card_clk_prev_q;
    idle_cnt_d = idle_cnt_q;
    if (active_s) begin
      idle_cnt_d = 4'h0; // [R11]
    end else if (card_edge && (idle_cnt_q < CSPC_IDLE_CLOCKS)) begin
      idle_cnt_d = idle_cnt_q + 4'h1;
    end
    idle_done = (idle_cnt_q == CSPC_IDLE_CLOCKS) && !active_s;
    // policy set ignores the host request, clear needs it as well
    idle_wanted = idle_done && (ctrl_q.stop_policy || host_stop_s); // [R1] [R2]

    cr_d = cr_q;
    case (cr_q)
      CSPC_CR_RUN: begin
        if (ctl_enable_q && idle_wanted) begin // [R9]
          cr_d = select_q ? CSPC_CR_SLOW : CSPC_CR_STOP; // [R10]
        end
      end
      CSPC_CR_STOP, CSPC_CR_SLOW: begin
        if (active_s || !ctl_enable_q || !idle_wanted) begin
          cr_d = CSPC_CR_RUN; // [R9]
        end
      end
      default: begin
        cr_d = CSPC_CR_RUN;
      end
    endcase
    stop_d = (cr_d == CSPC_CR_STOP);
    slow_d = (cr_d == CSPC_CR_SLOW);
    divisor_d = slow_d ? CSPC_DIV_SLOW : CSPC_DIV_NORMAL; // [R10]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= CSPC_CTRL_RESET;
      ctl_enable_q <= 1'b0;
      select_q <= 1'b0;
      accessed_q <= 1'b0;
      irq_stat_q <= CSPC_IRQ_RESET;
      irq_mask_q <= CSPC_IRQ_RESET;
      irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      card_clk_prev_q <= 1'b0;
      active_prev_q <= 1'b0;
      idle_cnt_q <= 4'h0;
      cr_q <= CSPC_CR_RUN;
      stop_q <= 1'b0;
      slow_q <= 1'b0;
      divisor_q <= CSPC_DIV_NORMAL;
    end else if (clk_en_in) begin
      ctrl_q <= ctrl_d;
      ctl_enable_q <= ctl_enable_d;
      select_q <= select_d;
      accessed_q <= accessed_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      card_clk_prev_q <= card_clk_s;
      active_prev_q <= active_s;
      idle_cnt_q <= idle_cnt_d;
      cr_q <= cr_d;
      stop_q <= stop_d;
      slow_q <= slow_d;
      divisor_q <= divisor_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign card_supply_out = ctrl_q.card_supply;
  assign prog_supply_out = ctrl_q.prog_supply;
  assign card_clk_stop_req_out = stop_q;
  assign card_clk_slow_req_out = slow_q;
  assign card_clk_divisor_out = divisor_q;
  assign irq_out = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence enter_stop_s;
    clk_en_in && (cr_q == CSPC_CR_RUN) ##1 stop_q;
  endsequence

  sequence pm_read_s;
    clk_en_in && rd_pm && !access_evt;
  endsequence

  idle_restart_a: assert property (clk_en_in && active_s |=> idle_cnt_q == 4'h0) // [R11]
    else $error("idle counter did not restart on activity");

  host_gated_stop_a: assert property (enter_stop_s ##0 !$past(ctrl_q.stop_policy) // [R1]
    |-> $past(host_stop_s) && $past(idle_cnt_q) == 4'h8)
    else $error("stop requested without host request and 8 idle clocks");

  free_stop_a: assert property ($rose(stop_q) |-> $past(idle_cnt_q) == 4'h8 && !$past(active_s)) // [R2]
    else $error("stop requested before 8 idle clocks");

  policy_stop_a: assert property (clk_en_in && cr_q == CSPC_CR_RUN && ctl_enable_q && !select_q // [R2]
    && ctrl_q.stop_policy && idle_done |=> stop_q)
    else $error("idle stop not requested with policy set");

  supply_legal_a: assert property (!(card_supply_out inside {3'h1, 3'h6, 3'h7}) // [R3]
    && !(prog_supply_out inside {3'h6, 3'h7}))
    else $error("supply output holds a reserved code");

  refused_write_a: assert property (clk_en_in && wr_ctrl && !card_ok && caps_s.present // [R5]
    |=> card_supply_out == $past(card_supply_out))
    else $error("unacceptable card supply taken");

  reserved_zero_a: assert property (reg_rd_in && reg_addr_in == CSPC_OFS_CTRL && clk_en_in // [R6]
    |=> reg_rdata_out[31:8] == 24'h0 && reg_rdata_out[3] == 1'b0)
    else $error("reserved control bits not zero");

  // the second read data only move when the enable was high one cycle earlier
  read_clear_a: assert property (pm_read_s |=> !accessed_q ##1 (reg_rdata_out[25] == 1'b0 // [R7]
    || !$past(clk_en_in)))
    else $error("access flag not cleared by read");

  mode_flag_a: assert property (reg_rd_in && rd_pm && clk_en_in // [R8]
    |=> reg_rdata_out[24] == $past(stop_q | slow_q))
    else $error("clock changed flag wrong");

  enable_off_a: assert property (clk_en_in && !ctl_enable_q |=> !stop_q && !slow_q) // [R9]
    else $error("clock control active while disabled");

  slow_div_a: assert property (slow_q |-> card_clk_divisor_out == 5'h10 && !stop_q) // [R10]
    else $error("slow mode without divide by 16");

endmodule
